/* File: design/bcec_pkg.sv */
// Constants, register map and types shared by the chain follower and event counter block.
//
// What this block does
// [RL1] Keep next pointer per receive/transmit chain.
// [RL2] Advanced bit set beyond buffer, clear at zero.
// [RL3] Host removes last buffer only after advance.
// [RL4] Pulse an event on every chain advance.
// [RL5] Host-set bits never set by device, vice versa.
// [RL6] Device-cleared bits never cleared by host, vice versa.
// [RL7] Discipline covers memory and register bits, not counters.
// [RL8] Host sets next-address request; device clears it.
// [RL9] One memory job at a time, no deadlock.
// [RL10] Count each event, saturate at 255.
// [RL11] Host alone clears the event counters.
// [RL12] Scan-mode frame: count, next station = own+1.
// [RL13] Count retries answered after silent first try.
// [RL14] Count transmit aborts: underrun or over 16 buffers.
// [RL15] Count network-dead timer expiries.
// [RL16] Count damaged supervisory frames received.
// [RL17] Count damaged data frames received.
// [RL18] Count every negative acknowledge sent.
// [RL19] Count abnormal or invalid frames.
// [RL20] Count duplicate token conditions.
// [RL21] Count each diagnostic set start.
// [RL22] Count data frames carrying own source address.
// [RL23] Counters sit at control block +5 to +F.
// [RL24] Touch a counter only on its event.
// [RL25] Counter update is read, increment, write back.
package bcec_pkg;

  // Counter and address geometry.
  localparam int unsigned NUM_CNT = 11;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned IDX_W   = 4;

  // Control block layout relative to the control block pointer.
  localparam logic [15:0] CB_RX_LINK_OFS = 16'h0000;
  localparam logic [15:0] CB_TX_LINK_OFS = 16'h0002;
  localparam logic [15:0] CB_CNT_BASE    = 16'h0005;
  localparam logic [15:0] BUF_LINK_OFS   = 16'h0000;
  localparam logic [15:0] LINK_LO_STEP   = 16'h0001;
  localparam logic [15:0] NULL_LINK      = 16'h0000;

  // Counter saturation value and station increment.
  localparam logic [7:0]  CNT_MAX  = 8'hFF;
  localparam logic [7:0]  CNT_STEP = 8'h01;
  localparam logic [7:0]  NSA_INC  = 8'h01;

  // Event vector positions.
  localparam int unsigned EVT_SCAN = 0;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CBP    = 8'h04;
  localparam logic [7:0] REG_OWN    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RXPTR  = 8'h10;
  localparam logic [7:0] REG_TXPTR  = 8'h14;
  localparam logic [7:0] REG_PEND   = 8'h18;

  // Field positions.
  localparam int unsigned CTRL_ENTER_BIT = 0;
  localparam int unsigned CTRL_NNA_BIT   = 1;
  localparam int unsigned ST_RX_ADV_BIT  = 0;
  localparam int unsigned ST_TX_ADV_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT    = 2;
  localparam int unsigned ST_NNA_BIT     = 3;
  localparam int unsigned ST_NSA_LSB     = 8;

  // Reset values.
  localparam logic [15:0] CBP_RST = 16'h0000;
  localparam logic [7:0]  OWN_RST = 8'h00;

  // Memory job sequencer, Gray coded along the usual path.
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_LNK_HI = 3'b001,
    S_LNK_LO = 3'b011,
    S_CNT_RD = 3'b010,
    S_CNT_WR = 3'b110
  } bcec_state_t;

endpackage

/* File: design/bcec_top.sv */
// Chain follower and memory event counter engine with an AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module bcec_top
  import bcec_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire logic [NUM_CNT-1:0]  event_pulse,
  input  wire logic                rx_buffer_taken,
  input  wire logic                tx_buffer_taken,
  output logic                     dma_req,
  output logic                     dma_we,
  output logic [ADDR_W-1:0]        dma_addr,
  output logic [7:0]               dma_wdata,
  input  wire logic                dma_ack,
  input  wire logic [7:0]          dma_rdata,
  output logic                     rx_chain_advanced,
  output logic                     tx_chain_advanced,
  output logic                     rx_advance_event,
  output logic                     tx_advance_event,
  output logic [7:0]               next_station_address
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic              ap_valid_q;
  logic              ap_write_q;
  logic [7:0]        ap_addr_q;
  logic [31:0]       hrdata_q;
  logic [31:0]       rd_word;
  logic              ap_take;
  logic              wr_en;
  logic [15:0]       cbp_q;
  logic [7:0]        own_q;
  logic              nna_q;
  logic              nna_seen_q;
  logic              host_nna_set;
  logic              enter_pulse;
  logic              nna_done;
  bcec_state_t       state_q;
  logic              dma_req_q;
  logic              dma_we_q;
  logic [15:0]       dma_addr_q;
  logic [7:0]        dma_wdata_q;
  logic [7:0]        link_hi_q;
  logic              chain_q;
  logic [IDX_W-1:0]  cnt_idx_q;
  logic [15:0]       rx_ptr_q;
  logic [15:0]       tx_ptr_q;
  logic              rx_adv_q;
  logic              tx_adv_q;
  logic              rx_evt_q;
  logic              tx_evt_q;
  logic [1:0]        fetch_pend_q;
  logic [NUM_CNT-1:0] cnt_pend_q;
  logic [7:0]        nsa_q;
  logic              start_fetch;
  logic              start_cnt;
  logic              fetch_done;
  logic [15:0]       link_word;
  logic              busy;
  logic [IDX_W-1:0]  next_idx;

  // Address of one counter byte inside the control block.
  function automatic logic [15:0] cnt_addr(input logic [15:0] base, input logic [IDX_W-1:0] idx);
    cnt_addr = base + CB_CNT_BASE + {12'h000, idx};
  endfunction

  // Saturating byte increment.
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == CNT_MAX) ? CNT_MAX : v + CNT_STEP;
  endfunction

  // Index of the lowest set bit of the pending vector.
  function automatic logic [IDX_W-1:0] lowest_set(input logic [NUM_CNT-1:0] v);
    lowest_set = '0;
    for (int i = NUM_CNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = IDX_W'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, stalls only while the clock enable is low.

  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign ap_take   = hsel && htrans[1] && hready && clk_en;
  assign wr_en     = ap_valid_q && ap_write_q && clk_en;

  // Address phase capture; only whole-word transfers are expected.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
    end else if (clk_en) begin
      ap_valid_q <= ap_take && (haddr[31:8] == 24'h000000);
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_word = 32'h00000000;
    case (haddr[7:0])
      REG_CTRL: begin
        rd_word[CTRL_NNA_BIT] = nna_q;
      end
      REG_CBP: begin
        rd_word[15:0] = cbp_q;
      end
      REG_OWN: begin
        rd_word[7:0] = own_q;
      end
      REG_STATUS: begin
        rd_word[ST_RX_ADV_BIT]            = rx_adv_q;
        rd_word[ST_TX_ADV_BIT]            = tx_adv_q;
        // Busy also covers queued jobs, so a poll never lands in the idle cycle between two jobs.
        rd_word[ST_BUSY_BIT]              = busy || (fetch_pend_q != 2'b00) || (cnt_pend_q != '0);
        rd_word[ST_NNA_BIT]               = nna_q;
        rd_word[ST_NSA_LSB +: 8]          = nsa_q;
      end
      REG_RXPTR: begin
        rd_word[15:0] = rx_ptr_q;
      end
      REG_TXPTR: begin
        rd_word[15:0] = tx_ptr_q;
      end
      REG_PEND: begin
        rd_word[NUM_CNT-1:0] = cnt_pend_q;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
    if (haddr[31:8] != 24'h000000) begin
      rd_word = 32'h00000000;
    end
  end

  // Read data is registered at the address phase and stands through the data phase.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_q <= 32'h00000000;
    end else if (clk_en && ap_take && !hwrite) begin
      hrdata_q <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-written configuration.

  assign enter_pulse  = wr_en && (ap_addr_q == REG_CTRL) && hwdata[CTRL_ENTER_BIT];
  assign host_nna_set = wr_en && (ap_addr_q == REG_CTRL) && hwdata[CTRL_NNA_BIT];

  // Control block pointer and own station address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cbp_q <= CBP_RST;
      own_q <= OWN_RST;
    end else if (wr_en) begin
      if (ap_addr_q == REG_CBP) begin
        cbp_q <= hwdata[15:0];
      end
      if (ap_addr_q == REG_OWN) begin
        own_q <= hwdata[7:0];
      end
    end
  end

  // Request bit: writing zero does nothing, so only the device ever clears it.
  assign nna_done = nna_seen_q && (fetch_pend_q == 2'b00) && !start_fetch &&
                    (state_q != S_LNK_HI) && (state_q != S_LNK_LO);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nna_q      <= 1'b0;
      nna_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (host_nna_set) begin
        nna_q      <= 1'b1; // [RL8] [RL5] [RL7]
        nna_seen_q <= 1'b0;
      end else if (nna_q && !nna_seen_q) begin
        nna_seen_q <= 1'b1;
      end else if (nna_done) begin
        nna_q      <= 1'b0; // [RL8] [RL6]
        nna_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending work: chain link fetches and counter updates.

  assign busy        = (state_q != S_IDLE);
  assign start_fetch = !busy && (fetch_pend_q != 2'b00);
  assign start_cnt   = !busy && (fetch_pend_q == 2'b00) && (cnt_pend_q != '0);
  assign next_idx    = lowest_set(cnt_pend_q);
  assign fetch_done  = (state_q == S_LNK_LO) && dma_ack;
  assign link_word   = {link_hi_q, dma_rdata};

  // Fetch requests: network entry, buffer taken into use, host extended a resting chain.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_pend_q <= 2'b00;
    end else if (clk_en) begin
      if (start_fetch) begin
        fetch_pend_q[fetch_pend_q[0] ? 0 : 1] <= 1'b0;
      end
      if (enter_pulse) begin
        fetch_pend_q <= 2'b11;
      end
      if (rx_buffer_taken && rx_adv_q) begin
        fetch_pend_q[0] <= 1'b1;
      end
      if (tx_buffer_taken && tx_adv_q) begin
        fetch_pend_q[1] <= 1'b1;
      end
      if (nna_q && !nna_seen_q) begin
        if (!rx_adv_q) begin
          fetch_pend_q[0] <= 1'b1;
        end
        if (!tx_adv_q) begin
          fetch_pend_q[1] <= 1'b1;
        end
      end
    end
  end

  // Counter events are sticky until serviced; a new event wins over the service clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_pend_q <= '0;
    end else if (clk_en) begin
      cnt_pend_q <= (cnt_pend_q & ~((start_cnt ? NUM_CNT'(1) : NUM_CNT'(0)) << next_idx))
                    | event_pulse; // [RL10] [RL13] [RL14] [RL15] [RL16] [RL17] [RL18] [RL19] [RL20] [RL21] [RL22]
    end
  end

  // Scan mode frame reloads the next station address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nsa_q <= 8'h00;
    end else if (clk_en && event_pulse[EVT_SCAN]) begin
      nsa_q <= own_q + NSA_INC; // [RL12]
    end
  end

  assign next_station_address = nsa_q;

  ////////////////////////////////////////////////////////////////////////////
  // Memory job sequencer: one job runs to completion before the next starts.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= S_IDLE;
      dma_req_q   <= 1'b0;
      dma_we_q    <= 1'b0;
      dma_addr_q  <= 16'h0000;
      dma_wdata_q <= 8'h00;
      link_hi_q   <= 8'h00;
      chain_q     <= 1'b0;
      cnt_idx_q   <= '0;
    end else if (clk_en) begin
      case (state_q)
        S_IDLE: begin
          if (start_fetch) begin
            chain_q    <= !fetch_pend_q[0];
            dma_addr_q <= (fetch_pend_q[0] ? rx_ptr_q : tx_ptr_q) + BUF_LINK_OFS; // [RL9]
            dma_req_q  <= 1'b1;
            dma_we_q   <= 1'b0;
            state_q    <= S_LNK_HI;
          end else if (start_cnt) begin
            cnt_idx_q  <= next_idx;
            dma_addr_q <= cnt_addr(cbp_q, next_idx); // [RL23] [RL24]
            dma_req_q  <= 1'b1;
            dma_we_q   <= 1'b0;
            state_q    <= S_CNT_RD;
          end
        end
        S_LNK_HI: begin
          if (dma_ack) begin
            link_hi_q  <= dma_rdata;
            dma_addr_q <= dma_addr_q + LINK_LO_STEP;
            state_q    <= S_LNK_LO;
          end
        end
        S_LNK_LO: begin
          if (dma_ack) begin
            dma_req_q <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        S_CNT_RD: begin
          if (dma_ack) begin
            dma_wdata_q <= sat_inc(dma_rdata); // [RL10] [RL25]
            dma_we_q    <= 1'b1;
            state_q     <= S_CNT_WR;
          end
        end
        S_CNT_WR: begin
          if (dma_ack) begin
            dma_req_q <= 1'b0;
            dma_we_q  <= 1'b0;
            state_q   <= S_IDLE;
          end
        end
        default: begin
          dma_req_q <= 1'b0;
          dma_we_q  <= 1'b0;
          state_q   <= S_IDLE;
        end
      endcase
    end
  end

  assign dma_req   = dma_req_q;
  assign dma_we    = dma_we_q;
  assign dma_addr  = dma_addr_q;
  assign dma_wdata = dma_wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Chain pointers: a non-zero link advances, a zero link leaves the pointer resting.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ptr_q <= 16'h0000;
      tx_ptr_q <= 16'h0000;
      rx_adv_q <= 1'b0;
      tx_adv_q <= 1'b0;
      rx_evt_q <= 1'b0;
      tx_evt_q <= 1'b0;
    end else if (clk_en) begin
      rx_evt_q <= 1'b0;
      tx_evt_q <= 1'b0;
      if (enter_pulse) begin
        rx_ptr_q <= cbp_q + CB_RX_LINK_OFS; // [RL1]
        tx_ptr_q <= cbp_q + CB_TX_LINK_OFS;
        rx_adv_q <= 1'b0;
        tx_adv_q <= 1'b0;
      end else if (fetch_done) begin
        if (link_word != NULL_LINK) begin
          if (chain_q) begin
            tx_ptr_q <= link_word; // [RL1]
            tx_adv_q <= 1'b1; // [RL2] [RL3]
            tx_evt_q <= 1'b1; // [RL4]
          end else begin
            rx_ptr_q <= link_word;
            rx_adv_q <= 1'b1;
            rx_evt_q <= 1'b1;
          end
        end else if (chain_q) begin
          tx_adv_q <= 1'b0; // [RL2]
        end else begin
          rx_adv_q <= 1'b0;
        end
      end
    end
  end

  assign rx_chain_advanced = rx_adv_q;
  assign tx_chain_advanced = tx_adv_q;
  assign rx_advance_event  = rx_evt_q;
  assign tx_advance_event  = tx_evt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_sat_inc;
    @(posedge clk) disable iff (sys_rst)
      (state_q == S_CNT_RD && dma_ack && clk_en) |=>
        (dma_we && dma_wdata == (($past(dma_rdata) == CNT_MAX) ? CNT_MAX : $past(dma_rdata) + CNT_STEP));
  endproperty
  a_sat_inc: assert property (p_sat_inc) else $error("Counter write-back is not a saturating increment."); // [RL10]

  property p_wb_addr;
    @(posedge clk) disable iff (sys_rst)
      (state_q == S_CNT_RD && dma_ack && clk_en) |=> (dma_req && dma_addr == $past(dma_addr));
  endproperty
  a_wb_addr: assert property (p_wb_addr) else $error("Counter written back to a different address."); // [RL25]

  property p_cnt_addr;
    @(posedge clk) disable iff (sys_rst)
      (state_q == S_CNT_RD && dma_req) |->
        ((16'(dma_addr - cbp_q) == CB_CNT_BASE + 16'(cnt_idx_q)) && (cnt_idx_q <= IDX_W'(NUM_CNT - 1)));
  endproperty
  a_cnt_addr: assert property (p_cnt_addr) else $error("Counter address outside its control block slot."); // [RL23]

  property p_adv_evt;
    @(posedge clk) disable iff (sys_rst)
      $rose(rx_advance_event) |->
        (rx_chain_advanced && $past(fetch_done) && !$past(chain_q) && rx_ptr_q == $past(link_word));
  endproperty
  a_adv_evt: assert property (p_adv_evt) else $error("Advance event without a receive chain advance."); // [RL4]

  property p_zero_rest;
    @(posedge clk) disable iff (sys_rst)
      (fetch_done && !chain_q && link_word == NULL_LINK && !enter_pulse && clk_en) |=>
        (!rx_chain_advanced && $stable(rx_ptr_q) && !rx_advance_event);
  endproperty
  a_zero_rest: assert property (p_zero_rest) else $error("Zero link did not leave the receive pointer resting."); // [RL2]

  property p_link_adv;
    @(posedge clk) disable iff (sys_rst)
      (fetch_done && chain_q && link_word != NULL_LINK && !enter_pulse && clk_en) |=>
        (tx_chain_advanced && tx_advance_event && tx_ptr_q == $past(link_word));
  endproperty
  a_link_adv: assert property (p_link_adv) else $error("Transmit pointer did not take the fetched link."); // [RL1]

  property p_nna_rise;
    @(posedge clk) disable iff (sys_rst)
      $rose(nna_q) |-> $past(host_nna_set);
  endproperty
  a_nna_rise: assert property (p_nna_rise) else $error("Request bit set without a host write."); // [RL8]

  property p_nna_fall;
    @(posedge clk) disable iff (sys_rst)
      $fell(nna_q) |-> ($past(fetch_pend_q) == 2'b00 && !$past(host_nna_set));
  endproperty
  a_nna_fall: assert property (p_nna_fall) else $error("Request bit cleared before its fetches ended."); // [RL6]

  property p_scan;
    @(posedge clk) disable iff (sys_rst)
      (event_pulse[EVT_SCAN] && clk_en) |=> (next_station_address == $past(own_q) + NSA_INC);
  endproperty
  a_scan: assert property (p_scan) else $error("Next station address not own address plus one."); // [RL12]

  property p_one_op;
    @(posedge clk) disable iff (sys_rst)
      dma_we |-> (dma_req && state_q == S_CNT_WR);
  endproperty
  a_one_op: assert property (p_one_op) else $error("Memory write outside the counter write-back step."); // [RL9]

  property p_pend;
    @(posedge clk) disable iff (sys_rst)
      ((|event_pulse) && clk_en) |=> ((cnt_pend_q & $past(event_pulse)) == $past(event_pulse));
  endproperty
  a_pend: assert property (p_pend) else $error("Counter event lost."); // [RL24]

endmodule

/* File: test/bcec_mem_model.sv */
// Byte-wide host memory model that answers the block's DMA requests.
`timescale 1ns/1ps
module bcec_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        dma_req,
  input  wire logic        dma_we,
  input  wire logic [15:0] dma_addr,
  input  wire logic [7:0]  dma_wdata,
  output logic             dma_ack,
  output logic [7:0]       dma_rdata
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Each request waits ack_delay cycles, then one ack pulse completes exactly one byte access.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_ack   <= 1'b0;
      wait_q    <= 4'h0;
      dma_rdata <= 8'h00;
    end else begin
      dma_ack   <= 1'b0;
      dma_rdata <= ~dma_rdata;  // Read data means nothing outside the ack cycle.
      if (dma_req && !dma_ack) begin
        if (wait_q >= ack_delay) begin
          dma_ack   <= 1'b1;
          dma_rdata <= mem[dma_addr];
          if (dma_we) begin
            mem[dma_addr] <= dma_wdata;
          end
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

/* File: test/tb_bcec_top.sv */
// Self-checking bench for the chain follower and event counter block.
`timescale 1ns/1ps
module tb_bcec_top
  import bcec_pkg::*;
;
  localparam logic [15:0] CBP = 16'h0100;
  logic               clk, sys_rst, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [NUM_CNT-1:0] event_pulse;
  logic               rx_buffer_taken, tx_buffer_taken, dma_req, dma_we, dma_ack;
  logic               rx_chain_advanced, tx_chain_advanced, rx_advance_event, tx_advance_event;
  logic [15:0]        dma_addr;
  logic [7:0]         dma_wdata, dma_rdata, next_station_address, iv;
  logic [3:0]         ack_delay;
  int                 errors = 0, total_checks = 0, cyc = 0, rx_ev = 0, tx_ev = 0;

  bcec_top u_bcec_top (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .event_pulse(event_pulse),
    .rx_buffer_taken(rx_buffer_taken), .tx_buffer_taken(tx_buffer_taken), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata), .rx_chain_advanced(rx_chain_advanced), .tx_chain_advanced(tx_chain_advanced),
    .rx_advance_event(rx_advance_event), .tx_advance_event(tx_advance_event),
    .next_station_address(next_station_address));

  bcec_mem_model u_bcec_mem_model (.clk(clk), .sys_rst(sys_rst), .ack_delay(ack_delay), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // The clock toggles every 10 ns, a half period of the 20 ns period.
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One AHB-Lite single word transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Register shorthands and a poll on the busy flag.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
  endtask
  task automatic rr(input logic [7:0] a);
    bus(1'b0, {24'h0, a}, 32'h0);
  endtask
  task automatic wait_idle();
    repeat (4) @(posedge clk);
    do rr(REG_STATUS); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic put16(input logic [15:0] a, input logic [15:0] v);
    u_bcec_mem_model.mem[a]         = v[15:8];
    u_bcec_mem_model.mem[a + 16'h1] = v[7:0];
  endtask
  function automatic logic [7:0] init_val(input int i);
    return (i == 5) ? 8'hFF : (i == 6) ? 8'hFE : 8'(i * 16);
  endfunction

  // Counts advance pulses and cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_advance_event === 1'b1) rx_ev <= rx_ev + 1;
    if (tx_advance_event === 1'b1) tx_ev <= tx_ev + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {sys_rst, clk_en, hsel, hwrite, rx_buffer_taken, tx_buffer_taken} = 6'b110000;
    {haddr, hwdata, htrans, event_pulse, ack_delay} = '0;
    hsize = 3'b010;
    for (int a = 0; a < 65536; a++) u_bcec_mem_model.mem[a] = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rr(REG_CBP);    check(rd, 32'h0);
    rr(REG_STATUS); check(rd, 32'h0);
    // Receive chain has one buffer with a zero link; transmit chain starts empty.
    put16(CBP, 16'h0200);
    put16(16'h0200, 16'h0000);
    wr(REG_CBP, {16'h0, CBP});
    wr(REG_OWN, 32'h42);
    wr(REG_CTRL, 32'h1);
    wait_idle();
    rr(REG_RXPTR);  check(rd, 32'h0200);
    rr(REG_TXPTR);  check(rd, {16'h0, CBP + 16'h2});
    rr(REG_STATUS); check({28'h0, rd[3:0]}, 32'h1);
    check(32'(rx_ev), 32'h1);
    check(32'(tx_ev), 32'h0);
    // Host extends the empty chain, then asks for a new next address over slow memory.
    put16(CBP + 16'h2, 16'h0300);
    ack_delay <= 4'hF;
    wr(REG_CTRL, 32'h2);
    wr(REG_CTRL, 32'h0);
    rr(REG_CTRL);   check({31'h0, rd[CTRL_NNA_BIT]}, 32'h1);
    wait_idle();
    rr(REG_TXPTR);  check(rd, 32'h0300);
    rr(REG_STATUS); check({28'h0, rd[3:0]}, 32'h3);
    check(32'(tx_ev), 32'h1);
    // Both chains take their buffer; the links there are zero, so the pointers rest.
    @(posedge clk) {rx_buffer_taken, tx_buffer_taken} <= 2'b11;
    @(posedge clk) {rx_buffer_taken, tx_buffer_taken} <= 2'b00;
    wait_idle();
    rr(REG_RXPTR);  check(rd, 32'h0200);
    rr(REG_TXPTR);  check(rd, 32'h0300);
    rr(REG_STATUS); check({28'h0, rd[3:0]}, 32'h0);
    check(32'(rx_ev + tx_ev), 32'h2);
    // Host presets every counter; all events fire in one cycle and none may be lost.
    ack_delay <= 4'h2;
    for (int i = 0; i < 11; i++) u_bcec_mem_model.mem[CBP + 16'(5 + i)] = init_val(i);
    u_bcec_mem_model.mem[CBP + 16'h4]  = 8'h5A;
    u_bcec_mem_model.mem[CBP + 16'h10] = 8'hA5;
    @(posedge clk) event_pulse <= 11'h7FF;
    @(posedge clk) event_pulse <= 11'h000;
    wait_idle();
    for (int i = 0; i < 11; i++) begin
      iv = init_val(i);
      check({24'h0, u_bcec_mem_model.mem[CBP + 16'(5 + i)]},
            {24'h0, (iv == 8'hFF) ? iv : iv + 8'h1});
    end
    check({24'h0, u_bcec_mem_model.mem[CBP + 16'h4]}, 32'h5A);
    check({24'h0, u_bcec_mem_model.mem[CBP + 16'h10]}, 32'hA5);
    check({24'h0, next_station_address}, 32'h43);
    // A single scan event touches its own counter and no other.
    @(posedge clk) event_pulse <= 11'h001;
    @(posedge clk) event_pulse <= 11'h000;
    wait_idle();
    check({24'h0, u_bcec_mem_model.mem[CBP + 16'h5]}, 32'h02);
    check({24'h0, u_bcec_mem_model.mem[CBP + 16'h6]}, 32'h11);
    rr(REG_PEND);   check(rd, 32'h0);
    // Read-only and unmapped places ignore writes; unmapped places read zero.
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rr(REG_STATUS); check(rd, 32'h0000_4300);
    wr(8'h1C, 32'hFFFF_FFFF);
    rr(8'h1C);      check(rd, 32'h0);
    bus(1'b0, 32'h0100_0004, 32'h0); check(rd, 32'h0);
    // With the clock enable low the bus stalls.
    @(posedge clk) clk_en <= 1'b0;
    @(posedge clk) #1 check({31'h0, hreadyout}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    @(posedge clk) clk_en <= 1'b1;
    finish_test();
  end
endmodule
